/* File: design/lfwd_cnt_if.sv */
`timescale 1ns/1ps
// ==========================================================================
// Link between control logic and the interval counter
interface lfwd_cnt_if;
    logic tick;
    logic restart;
    logic active;
    logic [lfwd_pkg::IVL_W-1:0] interval;
    logic overflow;

    modport ctl (output tick, output restart, output active, output interval, input overflow);
    modport cnt (input tick, input restart, input active, input interval, output overflow);
endinterface

/* File: design/lfwd_counter.sv */
`timescale 1ns/1ps
// ==========================================================================
// Interval counter: counts oscillator ticks, flags overflow
module lfwd_counter
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic nrst_in,
    // Control link
    lfwd_cnt_if.cnt cif
);

    logic [lfwd_pkg::CNT_W-1:0] cnt_q;
    logic [lfwd_pkg::CNT_W-1:0] cnt_d;
    logic ovf_q;
    logic ovf_d;
    logic [4:0] shamt;
    logic [lfwd_pkg::CNT_W:0] limit_full;
    logic [lfwd_pkg::CNT_W-1:0] limit_m1;

    // Terminal count from the interval field
    always_comb
    begin
        shamt = {1'b0, cif.interval, 1'b0} + lfwd_pkg::SHIFT_BIAS; // see R8
        limit_full = ({{lfwd_pkg::CNT_W{1'b0}}, 1'b1} << shamt) - {{lfwd_pkg::CNT_W{1'b0}}, 1'b1};
        limit_m1 = limit_full[lfwd_pkg::CNT_W-1:0];
    end

    // Next count and overflow pulse
    always_comb
    begin
        cnt_d = cnt_q;
        ovf_d = 1'b0;
        if (cif.restart || !cif.active)
        begin
            cnt_d = '0; // see R4
        end
        else if (cif.tick)
        begin
            if (cnt_q >= limit_m1)
            begin
                cnt_d = '0;
                ovf_d = 1'b1; // see R8
            end
            else
            begin
                cnt_d = cnt_q + {{(lfwd_pkg::CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // Count registers
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            cnt_q <= '0;
            ovf_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            ovf_q <= ovf_d;
        end
    end

    assign cif.overflow = ovf_q;

endmodule // lfwd_counter

/* File: design/lfwd_pkg.sv */
// ==========================================================================
// Constants shared by the watchdog modules
package lfwd_pkg;

    // ======================================================================
    // Register map
    localparam logic [7:0] WDC_OFFSET = 8'h97;

    // ======================================================================
    // Command codes written to watchdog_control
    localparam logic [7:0] CMD_ENABLE = 8'hA5;
    localparam logic [7:0] CMD_DIS_FIRST = 8'hDE;
    localparam logic [7:0] CMD_DIS_SECOND = 8'hAD;
    localparam logic [7:0] CMD_LOCKOUT = 8'hFF;

    // ======================================================================
    // Field positions and reset values
    localparam int CMD_BIT = 7;
    localparam int ACTIVE_BIT = 4;
    localparam int IVL_W = 3;
    localparam logic [2:0] IVL_RESET = 3'h7;
    localparam logic ACTIVE_RESET = 1'b1;

    // ======================================================================
    // Counting: interval = 4^(field+3) oscillator periods = 2^(2*field+6)
    localparam int CNT_W = 20;
    localparam logic [4:0] SHIFT_BIAS = 5'h06;

    // ======================================================================
    // Disable sequence window, in system clock cycles
    localparam logic [2:0] DIS_WINDOW_CYC = 3'h4;

    // ======================================================================
    // Disable sequencer states
    typedef enum logic [1:0]
    {
        DIS_IDLE = 2'h1,
        DIS_ARMED = 2'h2
    } lfwd_dis_state_type;

endpackage

/* File: design/lfwd_watchdog.sv */
`timescale 1ns/1ps
// ==========================================================================
// Overview of operation
// R1 - Overflow while active forces a whole-device reset.
// R2 - After reset the watchdog runs enabled with the longest interval.
// R3 - Counter runs from the low-frequency oscillator, forced on while active.
// R4 - Writing 0xA5 enables the watchdog and restarts its count.
// R5 - 0xDE then 0xAD within 4 clocks disables; later second write ignored.
// R6 - Writing 0xFF locks out disabling until the next reset.
// R7 - The lockout write neither enables nor restarts the watchdog.
// R8 - Timeout is oscillator period times four to the power field plus 3.
// R9 - Writes with bit 7 clear load the interval from bits 2 to 0.
// R10 - Reads return interval in bits 2 to 0, active flag in bit 4.
// R11 - Interval field reads 111 right after reset.
// R12 - Watchdog reset is internal and never drives the reset pin.
// R13 - Software should write 0xA5 often enough to avoid overflow.
// R14 - Software should block interrupts around the two disable writes.
// R15 - Software keeping the watchdog always should write lockout at startup.
// R16 - Unknown bit-7 commands change nothing and cancel a pending disable.
// R17 - Oscillator input is synchronised before use; reset request is registered.
module lfwd_watchdog
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic nrst_in,
    // Low-frequency oscillator
    input wire logic lfo_clk_in,
    output logic lfo_force_on_out,
    // Special function register port
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    // Internal system reset request
    output logic sys_reset_out
);

    lfwd_cnt_if cif();

    // ======================================================================
    // Oscillator synchroniser and edge detect
    logic lfo_s1_q;
    logic lfo_s2_q;
    logic lfo_s3_q;
    logic tick_q;
    logic tick_d;

    always_comb
    begin
        tick_d = lfo_s2_q & ~lfo_s3_q; // see R3
    end

    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            lfo_s1_q <= 1'b0;
            lfo_s2_q <= 1'b0;
            lfo_s3_q <= 1'b0;
            tick_q <= 1'b0;
        end
        else
        begin
            lfo_s1_q <= lfo_clk_in; // see R17
            lfo_s2_q <= lfo_s1_q;
            lfo_s3_q <= lfo_s2_q;
            tick_q <= tick_d;
        end
    end

    // ======================================================================
    // Control register write decode
    logic wr_hit;
    logic is_enable;
    logic is_dis1;
    logic is_dis2;
    logic is_lock;
    logic is_ivl;

    always_comb
    begin
        wr_hit = sfr_wr_in && (sfr_addr_in == lfwd_pkg::WDC_OFFSET);
        is_enable = wr_hit && (sfr_wdata_in == lfwd_pkg::CMD_ENABLE);
        is_dis1 = wr_hit && (sfr_wdata_in == lfwd_pkg::CMD_DIS_FIRST);
        is_dis2 = wr_hit && (sfr_wdata_in == lfwd_pkg::CMD_DIS_SECOND);
        is_lock = wr_hit && (sfr_wdata_in == lfwd_pkg::CMD_LOCKOUT);
        is_ivl = wr_hit && !sfr_wdata_in[lfwd_pkg::CMD_BIT];
    end

    // ======================================================================
    // Watchdog state: interval, active, lockout, disable sequencer
    logic [2:0] interval_q;
    logic [2:0] interval_d;
    logic active_q;
    logic active_d;
    logic lock_q;
    logic lock_d;
    logic restart_q;
    logic restart_d;
    lfwd_pkg::lfwd_dis_state_type dis_st_q;
    lfwd_pkg::lfwd_dis_state_type dis_st_d;
    logic [2:0] win_q;
    logic [2:0] win_d;

    always_comb
    begin
        interval_d = interval_q;
        active_d = active_q;
        lock_d = lock_q;
        restart_d = 1'b0;
        dis_st_d = dis_st_q;
        win_d = (win_q != 3'h0) ? win_q - 3'h1 : 3'h0;
        if (is_ivl)
        begin
            interval_d = sfr_wdata_in[2:0]; // see R9
        end
        if (is_enable)
        begin
            active_d = 1'b1; // see R4
            restart_d = 1'b1;
        end
        if (is_lock)
        begin
            lock_d = 1'b1; // see R6, see R7
        end
        // Any watchdog_control write other than the two disable codes ends a pending sequence; a repeated first code restarts the window
        case (dis_st_q)
            lfwd_pkg::DIS_IDLE:
            begin
                if (is_dis1 && !lock_q)
                begin
                    dis_st_d = lfwd_pkg::DIS_ARMED;
                    win_d = lfwd_pkg::DIS_WINDOW_CYC;
                end
            end
            lfwd_pkg::DIS_ARMED:
            begin
                if (is_dis2 && (win_q != 3'h0) && !lock_q)
                begin
                    active_d = 1'b0; // see R5
                    dis_st_d = lfwd_pkg::DIS_IDLE;
                end
                else if (is_dis1 && !lock_q)
                begin
                    win_d = lfwd_pkg::DIS_WINDOW_CYC;
                end
                else if (wr_hit || win_q == 3'h0 || lock_q)
                begin
                    dis_st_d = lfwd_pkg::DIS_IDLE; // see R16, see R6
                end
            end
            default:
            begin
                dis_st_d = lfwd_pkg::DIS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            interval_q <= lfwd_pkg::IVL_RESET; // see R2, see R11
            active_q <= lfwd_pkg::ACTIVE_RESET;
            lock_q <= 1'b0;
            restart_q <= 1'b0;
            dis_st_q <= lfwd_pkg::DIS_IDLE;
            win_q <= 3'h0;
        end
        else
        begin
            interval_q <= interval_d;
            active_q <= active_d;
            lock_q <= lock_d;
            restart_q <= restart_d;
            dis_st_q <= dis_st_d;
            win_q <= win_d;
        end
    end

    // ======================================================================
    // Counter link
    assign cif.tick = tick_q;
    assign cif.restart = restart_q;
    assign cif.active = active_q;
    assign cif.interval = interval_q;

    lfwd_counter u_counter
    (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .cif(cif)
    );

    // ======================================================================
    // Outputs: readback, reset request, oscillator force
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic sys_rst_q;
    logic sys_rst_d;
    logic lfo_on_q;
    logic lfo_on_d;

    always_comb
    begin
        rdata_d = 8'h00;
        if (sfr_rd_in && (sfr_addr_in == lfwd_pkg::WDC_OFFSET))
        begin
            rdata_d[2:0] = interval_q; // see R10
            rdata_d[lfwd_pkg::ACTIVE_BIT] = active_q;
        end
        sys_rst_d = cif.overflow && active_q; // see R1, see R12
        lfo_on_d = active_q; // see R3
    end

    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rdata_q <= 8'h00;
            sys_rst_q <= 1'b0;
            lfo_on_q <= 1'b1;
        end
        else
        begin
            rdata_q <= rdata_d;
            sys_rst_q <= sys_rst_d;
            lfo_on_q <= lfo_on_d;
        end
    end

    assign sfr_rdata_out = rdata_q;
    assign sys_reset_out = sys_rst_q;
    assign lfo_force_on_out = lfo_on_q;

    // ======================================================================
    // Assertions and cover points
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);

    a_enable_restart: assert property (is_enable |=> active_q && restart_q) // see R4
        else $error("enable code did not enable and restart");
    a_lockout_quiet: assert property (is_lock |=> lock_q && !restart_q // see R7
        && active_q == $past(active_q))
        else $error("lockout write changed active state or restarted");
    a_interval_load: assert property (is_ivl |=> interval_q == $past(sfr_wdata_in[2:0])) // see R9
        else $error("interval not loaded");
    a_disable_fast: assert property (is_dis1 && !lock_q ##1 (!wr_hit)[*3] // see R5
        ##1 is_dis2 |=> !active_q)
        else $error("timely disable sequence not taken");
    a_disable_late: assert property (active_q && is_dis1 // see R5
        ##1 (!wr_hit)[*4] ##1 is_dis2 |=> active_q)
        else $error("late disable write was taken");
    a_lock_blocks: assert property (lock_q |=> lock_q ##0 (active_q || !$past(active_q))) // see R6
        else $error("disable taken under lockout");
    a_unknown_cmd: assert property (wr_hit && sfr_wdata_in[7] && !is_enable // see R16
        && !is_dis1 && !is_dis2 && !is_lock
        |=> $stable(interval_q) && $stable(active_q) && dis_st_q == lfwd_pkg::DIS_IDLE)
        else $error("unknown command changed state");
    a_overflow_reset: assert property (cif.overflow && active_q |=> sys_reset_out) // see R1
        else $error("overflow did not request reset");
    a_readback: assert property (sfr_rd_in && sfr_addr_in == lfwd_pkg::WDC_OFFSET // see R10
        |=> sfr_rdata_out == {3'h0, $past(active_q), 1'b0, $past(interval_q)})
        else $error("readback mismatch");
    a_lfo_forced: assert property (active_q |=> lfo_force_on_out) // see R3
        else $error("oscillator not forced on while active");

    c_overflow: cover property (sys_reset_out);
    c_disabled: cover property (active_q ##1 !active_q);
    c_locked: cover property (is_lock);
    c_restart: cover property (restart_q);

endmodule // lfwd_watchdog

/* File: tb/lfwd_watchdog_bench.sv */
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench for the watchdog control block
module lfwd_watchdog_bench;
    logic core_clk_in;
    logic nrst_in;
    logic lfo_clk_in;
    logic lfo_force_on_out;
    logic [7:0] sfr_addr_in;
    logic sfr_wr_in;
    logic sfr_rd_in;
    logic [7:0] sfr_wdata_in;
    logic [7:0] sfr_rdata_out;
    logic sys_reset_out;
    logic lfo_run;
    int lfo_div;
    int tick_n;
    int rst_pulses;
    int n_fail;
    int check_count;

    lfwd_watchdog u_lfwd_watchdog (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
        .lfo_clk_in(lfo_clk_in), .lfo_force_on_out(lfo_force_on_out),
        .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
        .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
        .sys_reset_out(sys_reset_out));

    // ======================================================================
    // System clock, 10 ns period
    initial
    begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end

    // Oscillator stand-in: 8 system clocks a period, parked low when stopped
    always @(posedge core_clk_in)
    begin
        if (!lfo_run)
        begin
            lfo_clk_in <= 1'b0;
            lfo_div <= 0;
        end
        else
        begin
            lfo_div <= (lfo_div + 1) % 4;
            if (lfo_div == 3)
            begin
                lfo_clk_in <= ~lfo_clk_in;
                if (!lfo_clk_in) tick_n <= tick_n + 1; // Count rising edges
            end
        end
        if (sys_reset_out === 1'b1) rst_pulses <= rst_pulses + 1;
    end

    // ======================================================================
    // Comparison and reporting tasks
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t read got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t flag got %b exp %b", $time, got, exp);
        end
    endtask

    task automatic chk_num(input int got, input int exp);
        check_count++;
        if (got != exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t count got %0d exp %0d", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ======================================================================
    // Register access tasks; writes are spaced 2 + gap cycles apart
    task automatic wr(input logic [7:0] addr, input logic [7:0] val, input int gap);
        @(posedge core_clk_in);
        sfr_addr_in <= addr;
        sfr_wdata_in <= val;
        sfr_wr_in <= 1'b1;
        @(posedge core_clk_in);
        sfr_wr_in <= 1'b0;
        repeat (gap) @(posedge core_clk_in);
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge core_clk_in);
        sfr_addr_in <= addr;
        sfr_rd_in <= 1'b1;
        @(posedge core_clk_in);
        sfr_rd_in <= 1'b0;
        #1;
        chk_byte(sfr_rdata_out, exp);
    endtask

    // Runs the oscillator for a number of ticks, then lets the sync chain drain
    task automatic lfo_for(input int ticks);
        @(posedge core_clk_in);
        lfo_run <= 1'b1;
        repeat (ticks * 8) @(posedge core_clk_in);
        lfo_run <= 1'b0;
        repeat (6) @(posedge core_clk_in);
    endtask

    // Restart with the oscillator stopped so no tick is in flight
    task automatic restart();
        wr(8'h97, 8'hA5, 0);
        tick_n = 0;
    endtask

    // Runs the oscillator until a reset request, checks its tick count and width
    task automatic run_until_reset(input int exp_ticks);
        int i;
        bit seen;
        seen = 1'b0;
        @(posedge core_clk_in);
        lfo_run <= 1'b1;
        for (i = 0; i < 4000 && !seen; i++)
        begin
            @(posedge core_clk_in);
            #1;
            seen = (sys_reset_out === 1'b1);
        end
        chk_bit(seen, 1'b1);
        chk_num(tick_n, exp_ticks);
        @(posedge core_clk_in);
        #1;
        chk_bit(sys_reset_out, 1'b0); // One-cycle request
        lfo_run <= 1'b0;
        repeat (6) @(posedge core_clk_in);
    endtask

    task automatic apply_reset();
        @(posedge core_clk_in);
        nrst_in <= 1'b0;
        repeat (3) @(posedge core_clk_in);
        nrst_in <= 1'b1;
    endtask

    // ======================================================================
    // Main sequence
    initial
    begin
        nrst_in = 1'b0;
        lfo_clk_in = 1'b0;
        lfo_run = 1'b0;
        sfr_addr_in = 8'h00;
        sfr_wr_in = 1'b0;
        sfr_rd_in = 1'b0;
        sfr_wdata_in = 8'h00;
        lfo_div = 0;
        tick_n = 0;
        rst_pulses = 0;
        n_fail = 0;
        check_count = 0;
        repeat (3) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        rd_chk(8'h97, 8'h17);
        chk_bit(lfo_force_on_out, 1'b1);
        rd_chk(8'h98, 8'h00);
        wr(8'h98, 8'h00, 0);
        rd_chk(8'h97, 8'h17);
        wr(8'h97, 8'h03, 0);
        rd_chk(8'h97, 8'h13);
        wr(8'h97, 8'h85, 0);
        rd_chk(8'h97, 8'h13);
        wr(8'h97, 8'hDE, 3);
        wr(8'h97, 8'hAD, 0);
        rd_chk(8'h97, 8'h13);
        wr(8'h97, 8'hDE, 0);
        wr(8'h97, 8'h85, 0);
        wr(8'h97, 8'hAD, 0);
        rd_chk(8'h97, 8'h13);
        wr(8'h97, 8'hDE, 2);
        wr(8'h97, 8'hAD, 0);
        rd_chk(8'h97, 8'h03);
        chk_bit(lfo_force_on_out, 1'b0);
        wr(8'h97, 8'h00, 0);
        lfo_for(80);
        chk_num(rst_pulses, 0);
        restart();
        rd_chk(8'h97, 8'h10);
        chk_bit(lfo_force_on_out, 1'b1);
        lfo_for(40);
        chk_num(rst_pulses, 0);
        restart();
        run_until_reset(64);
        chk_num(rst_pulses, 1);
        apply_reset();
        rd_chk(8'h97, 8'h17);
        wr(8'h97, 8'h01, 0);
        wr(8'h97, 8'hDE, 0);
        wr(8'h97, 8'hAD, 0);
        wr(8'h97, 8'hFF, 0);
        rd_chk(8'h97, 8'h01);
        restart();
        lfo_for(100);
        wr(8'h97, 8'hFF, 0);
        wr(8'h97, 8'hDE, 0);
        wr(8'h97, 8'hAD, 0);
        rd_chk(8'h97, 8'h11);
        run_until_reset(256);
        final_report();
    end

    // Watchdog on the bench itself: the tests need well under 10000 cycles
    initial
    begin
        #300000;
        n_fail++;
        $display("MISMATCH t=%0t run did not finish", $time);
        final_report();
    end
endmodule // lfwd_watchdog_bench
